// [rtl/sram_ctrl_map.svh]
// constants for the asynchronous sram host controller: pin timing, counts, resets
// assumes a single 100 ns system clock; the pin timing figures below are in ns, the rest are stage counts, bit positions and reset values
// ==========================================================
// Summary of operation
// - A write happens only while write strobe, both chip selects and a byte lane are active.
// - Write data setup and hold are measured from whichever control edge ends the write.
// - Address is held stable at least 35 ns (45 ns slow grade) before the write ends.
// - Address may change as soon as the write has ended, with 0 ns hold.
// - Address is valid no later than write start, with 0 ns setup.
// - Write data is valid at least 25 ns before the write-ending edge.
// - Write data may be released at the write-ending edge, with 0 ns hold.
// - A byte lane used in a write is asserted at least 35 ns (45 ns slow) before write end.
// - Write strobe lasts at least 35 ns (40 ns slow), and setup plus 18/20 ns if reads enabled.
// - The part is deselected by inactive chip selects or by both lane enables inactive.
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH

// ==========================================================
// clock and crossing
`define SRAM_CLK_PERIOD_NS 100
`define SRAM_SYNC_STAGES   2

// least time to whole cycles, never under one
`define SRAM_CYC_MIN(ns) ((((ns)+`SRAM_CLK_PERIOD_NS-1)/`SRAM_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns)+`SRAM_CLK_PERIOD_NS-1)/`SRAM_CLK_PERIOD_NS))

// ==========================================================
// pin timing, fast grade (_F) and slow grade (_S)
`define SRAM_T_RC_F   45
`define SRAM_T_RC_S   55
`define SRAM_T_AA_F   45
`define SRAM_T_AA_S   55
`define SRAM_T_OHA    10
`define SRAM_T_DOE_F  22
`define SRAM_T_DOE_S  25
`define SRAM_T_DBE_F  45
`define SRAM_T_DBE_S  55
`define SRAM_T_AW_F   35
`define SRAM_T_AW_S   45
`define SRAM_T_HA     0
`define SRAM_T_SA     0
`define SRAM_T_PWE_F  35
`define SRAM_T_PWE_S  40
`define SRAM_T_BW_F   35
`define SRAM_T_BW_S   45
`define SRAM_T_SD     25
`define SRAM_T_HD     0
`define SRAM_T_HZWE_F 18
`define SRAM_T_HZWE_S 20

// ==========================================================
// field positions and reset values
`define SRAM_LANE_LO   0
`define SRAM_LANE_HI   1
`define SRAM_ADDR_RST  18'h00000
`define SRAM_DATA_RST  16'h0000

`endif

// [rtl/sram_ctrl_pkg.sv]
// types shared by the sram host controller, the device model and the bench
// assumes the constants header is compiled alongside
package sram_ctrl_pkg;

  typedef logic [17:0] sram_addr_t;
  typedef logic [15:0] sram_data_t;
  typedef logic [1:0]  sram_lanes_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RD_ACC   = 3'b001,
    ST_WR_SETUP = 3'b010,
    ST_WR_PULSE = 3'b011,
    ST_WR_END   = 3'b100,
    ST_GAP      = 3'b101
  } state_t;

endpackage

// [rtl/sram_wait_timer.sv]
// loadable down counter for pin timing waits
// assumes load values already reduced to the wanted cycles minus one
module sram_wait_timer #(
  parameter int TMR_W = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] loadValue,
  // status
  output      logic             expired
);

  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;

  // ==========================================================
  // count
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == '0);

endmodule

// [rtl/sram_ctrl.sv]
// host controller driving an asynchronous 256k x 16 sram with corrected-error flag
// assumes one 10 MHz clock; data and error pins come from the part, unsynchronised
`include "sram_ctrl_map.svh"

module sram_ctrl #(
  parameter bit SLOW_GRADE = 1'b0,
  parameter int TMR_W      = 8
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // user request
  input  wire logic                      req,
  input  wire logic                      reqWrite,
  input  wire sram_ctrl_pkg::sram_addr_t  reqAddr,
  input  wire sram_ctrl_pkg::sram_data_t  reqData,
  input  wire sram_ctrl_pkg::sram_lanes_t reqLanes,
  output      logic                      ready,
  // user answer
  output      logic                      rspValid,
  output      sram_ctrl_pkg::sram_data_t  rspData,
  output      logic                      rspErr,
  // sram address and controls
  output      sram_ctrl_pkg::sram_addr_t  sramAddr,
  output      logic                      chip_select_low_active,
  output      logic                      chip_select_high_active,
  output      logic                      upper_byte_lane_n,
  output      logic                      lower_byte_lane_n,
  output      logic                      writeStrobeN,
  output      logic                      outEnableN,
  // sram data and error pins
  input  wire sram_ctrl_pkg::sram_data_t  dataIn,
  output      sram_ctrl_pkg::sram_data_t  dataOut,
  output      logic                      dataOe,
  input  wire logic                      errIn
);
  import sram_ctrl_pkg::*;

  // ==========================================================
  // timing in cycles
  function automatic int maxi(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int T_RC   = SLOW_GRADE ? `SRAM_T_RC_S   : `SRAM_T_RC_F;
  localparam int T_AA   = SLOW_GRADE ? `SRAM_T_AA_S   : `SRAM_T_AA_F;
  localparam int T_DOE  = SLOW_GRADE ? `SRAM_T_DOE_S  : `SRAM_T_DOE_F;
  localparam int T_DBE  = SLOW_GRADE ? `SRAM_T_DBE_S  : `SRAM_T_DBE_F;
  localparam int T_AW   = SLOW_GRADE ? `SRAM_T_AW_S   : `SRAM_T_AW_F;
  localparam int T_PWE  = SLOW_GRADE ? `SRAM_T_PWE_S  : `SRAM_T_PWE_F;
  localparam int T_BW   = SLOW_GRADE ? `SRAM_T_BW_S   : `SRAM_T_BW_F;
  localparam int T_HZWE = SLOW_GRADE ? `SRAM_T_HZWE_S : `SRAM_T_HZWE_F;

  // strobe long enough for address, lane and data setup, and for the oe-low case too
  localparam int WR_NS  = maxi(maxi(T_AW, T_BW), maxi(T_PWE, `SRAM_T_SD + T_HZWE));
  localparam int WR_CYC = `SRAM_CYC_MIN(WR_NS);
  localparam int SA_CYC = `SRAM_CYC_MIN(`SRAM_T_SA);
  localparam int HD_CYC = `SRAM_CYC_MIN(maxi(`SRAM_T_HD, `SRAM_T_HA));
  localparam int ACC_CYC = `SRAM_CYC_MIN(maxi(T_AA, maxi(T_DOE, T_DBE)));
  // pins pass the synchroniser before capture, so the access window grows by its depth
  localparam int RD_CYC = ACC_CYC + `SRAM_SYNC_STAGES;
  localparam int RC_CYC = `SRAM_CYC_MIN(T_RC);
  localparam int RD_LAT = RD_CYC;

  localparam logic [TMR_W-1:0] SA_LD = TMR_W'(SA_CYC - 1);
  localparam logic [TMR_W-1:0] WR_LD = TMR_W'(WR_CYC - 1);
  localparam logic [TMR_W-1:0] HD_LD = TMR_W'(HD_CYC - 1);
  localparam logic [TMR_W-1:0] RD_LD = TMR_W'(RD_CYC - 1);
  localparam logic [TMR_W-1:0] RC_LD = TMR_W'(RC_CYC - 1);

  // ==========================================================
  // input synchronisers
  sram_data_t dataSync1;
  sram_data_t dataSync2;
  logic       errSync1;
  logic       errSync2;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataSync1 <= `SRAM_DATA_RST;
      dataSync2 <= `SRAM_DATA_RST;
      errSync1  <= 1'b0;
      errSync2  <= 1'b0;
    end else begin
      dataSync1 <= dataIn;
      dataSync2 <= dataSync1;
      errSync1  <= errIn;
      errSync2  <= errSync1;
    end
  end

  // ==========================================================
  // timers
  logic             stepLoad;
  logic [TMR_W-1:0] stepValue;
  logic             stepDone;
  logic             gapLoad;
  logic             gapDone;

  sram_wait_timer #(.TMR_W(TMR_W)) stepTimer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (stepLoad),
    .loadValue (stepValue),
    .expired   (stepDone)
  );

  // cycle-time spacing runs from each access start, in parallel with the access
  sram_wait_timer #(.TMR_W(TMR_W)) gapTimer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (gapLoad),
    .loadValue (RC_LD),
    .expired   (gapDone)
  );

  // ==========================================================
  // access sequencer
  state_t      state;
  state_t      next_state;
  logic        opWrite;
  logic        next_opWrite;
  logic        next_ready;
  logic        next_rspValid;
  sram_data_t  next_rspData;
  logic        next_rspErr;
  sram_addr_t  next_sramAddr;
  logic        next_csLow;
  logic        next_csHigh;
  logic        next_upperN;
  logic        next_lowerN;
  logic        next_weN;
  logic        next_oeN;
  sram_data_t  next_dataOut;
  logic        next_dataOe;

  // lanes not enabled read back as zero
  function automatic sram_data_t laneMask(input sram_data_t d, input logic upN, input logic loN);
    return {upN ? 8'h00 : d[15:8], loN ? 8'h00 : d[7:0]};
  endfunction

  always_comb begin
    next_state    = state;
    next_opWrite  = opWrite;
    next_ready    = ready;
    next_rspValid = 1'b0;
    next_rspData  = rspData;
    next_rspErr   = rspErr;
    next_sramAddr = sramAddr;
    next_csLow    = chip_select_low_active;
    next_csHigh   = chip_select_high_active;
    next_upperN   = upper_byte_lane_n;
    next_lowerN   = lower_byte_lane_n;
    next_weN      = writeStrobeN;
    next_oeN      = outEnableN;
    next_dataOut  = dataOut;
    next_dataOe   = dataOe;
    stepLoad      = 1'b0;
    stepValue     = '0;
    gapLoad       = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (req && ready) begin
          next_ready    = 1'b0;
          next_opWrite  = reqWrite;
          // address, selects and lanes all move together, with output enable on a read, before the write strobe
          next_sramAddr = reqAddr;
          next_csLow    = 1'b0;
          next_csHigh   = 1'b1;
          next_upperN   = ~reqLanes[`SRAM_LANE_HI];
          next_lowerN   = ~reqLanes[`SRAM_LANE_LO];
          gapLoad       = 1'b1;
          stepLoad      = 1'b1;
          if (reqWrite) begin
            next_dataOut = reqData;
            next_dataOe  = 1'b1;
            stepValue    = SA_LD;
            next_state   = ST_WR_SETUP;
          end else begin
            next_oeN   = 1'b0;
            stepValue  = RD_LD;
            next_state = ST_RD_ACC;
          end
        end
      end
      ST_RD_ACC: begin
        if (stepDone) begin
          // capture before the address or enables move, inside the hold window
          next_rspData  = laneMask(dataSync2, upper_byte_lane_n, lower_byte_lane_n);
          // the flag pin floats with both lanes off, so such a read reports no correction
          next_rspErr   = errSync2 & ~(upper_byte_lane_n & lower_byte_lane_n);
          next_rspValid = 1'b1;
          next_oeN      = 1'b1;
          next_csLow    = 1'b1;
          next_csHigh   = 1'b0;
          next_upperN   = 1'b1;
          next_lowerN   = 1'b1;
          next_state    = ST_GAP;
        end
      end
      ST_WR_SETUP: begin
        if (stepDone) begin
          // no strobe when both lanes are off: the access keeps its timing but writes nothing
          next_weN   = upper_byte_lane_n & lower_byte_lane_n;
          stepLoad   = 1'b1;
          stepValue  = WR_LD;
          next_state = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (stepDone) begin
          // the strobe is always the ending edge; selects and lanes outlast it
          next_weN   = 1'b1;
          stepLoad   = 1'b1;
          stepValue  = HD_LD;
          next_state = ST_WR_END;
        end
      end
      ST_WR_END: begin
        if (stepDone) begin
          next_dataOe   = 1'b0;
          next_csLow    = 1'b1;
          next_csHigh   = 1'b0;
          next_upperN   = 1'b1;
          next_lowerN   = 1'b1;
          next_rspErr   = 1'b0;
          next_rspValid = 1'b1;
          next_state    = ST_GAP;
        end
      end
      ST_GAP: begin
        // at least one idle cycle lets the part release the bus after a read
        if (gapDone) begin
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
        next_weN   = 1'b1;
        next_oeN   = 1'b1;
        next_csLow = 1'b1;
        next_csHigh = 1'b0;
        next_dataOe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state                   <= ST_IDLE;
      opWrite                 <= 1'b0;
      ready                   <= 1'b1;
      rspValid                <= 1'b0;
      rspData                 <= `SRAM_DATA_RST;
      rspErr                  <= 1'b0;
      sramAddr                <= `SRAM_ADDR_RST;
      chip_select_low_active  <= 1'b1;
      chip_select_high_active <= 1'b0;
      upper_byte_lane_n       <= 1'b1;
      lower_byte_lane_n       <= 1'b1;
      writeStrobeN            <= 1'b1;
      outEnableN              <= 1'b1;
      dataOut                 <= `SRAM_DATA_RST;
      dataOe                  <= 1'b0;
    end else begin
      state                   <= next_state;
      opWrite                 <= next_opWrite;
      ready                   <= next_ready;
      rspValid                <= next_rspValid;
      rspData                 <= next_rspData;
      rspErr                  <= next_rspErr;
      sramAddr                <= next_sramAddr;
      chip_select_low_active  <= next_csLow;
      chip_select_high_active <= next_csHigh;
      upper_byte_lane_n       <= next_upperN;
      lower_byte_lane_n       <= next_lowerN;
      writeStrobeN            <= next_weN;
      outEnableN              <= next_oeN;
      dataOut                 <= next_dataOut;
      dataOe                  <= next_dataOe;
    end
  end

  // ==========================================================
  // checking helpers
  logic [TMR_W-1:0] weLowCnt;
  logic [TMR_W-1:0] next_weLowCnt;
  logic [TMR_W-1:0] sinceSel;
  logic [TMR_W-1:0] next_sinceSel;

  always_comb begin
    next_weLowCnt = '0;
    if (!writeStrobeN && weLowCnt != '1) begin
      next_weLowCnt = weLowCnt + 1'b1;
    end
    next_sinceSel = sinceSel;
    if (!next_csLow && chip_select_low_active) begin
      next_sinceSel = '0;
    end else if (sinceSel != '1) begin
      next_sinceSel = sinceSel + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      weLowCnt <= '0;
      sinceSel <= '1;
    end else begin
      weLowCnt <= next_weLowCnt;
      sinceSel <= next_sinceSel;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_end;
    $rose(writeStrobeN);
  endsequence

  sequence s_rd_start;
    $fell(outEnableN);
  endsequence

  property p_wr_overlap;
    !writeStrobeN |-> !chip_select_low_active && chip_select_high_active &&
      !(upper_byte_lane_n && lower_byte_lane_n);
  endproperty
  a_wr_overlap: assert property (p_wr_overlap) else $error("strobe low outside full select");

  property p_data_setup;
    !writeStrobeN |-> dataOe && $stable(dataOut) && outEnableN;
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("write data moved under strobe");

  property p_addr_write;
    !writeStrobeN |-> $stable(sramAddr);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address moved during write");

  property p_end_release;
    s_wr_end |-> dataOe && $stable(sramAddr) && !chip_select_low_active ##1 !dataOe;
  endproperty
  a_end_release: assert property (p_end_release) else $error("write end not by strobe");

  property p_lane_setup;
    $fell(writeStrobeN) |-> $stable({upper_byte_lane_n, lower_byte_lane_n});
  endproperty
  a_lane_setup: assert property (p_lane_setup) else $error("lane changed at write start");

  property p_pulse_width;
    s_wr_end |-> weLowCnt == TMR_W'(WR_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("write strobe width wrong");

  property p_rd_latency;
    s_rd_start |-> ##RD_LAT (rspValid && outEnableN && !opWrite);
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer not on time");

  property p_rd_addr;
    (!outEnableN && $past(!outEnableN)) |-> $stable(sramAddr) && !dataOe;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("address moved during read");

  property p_deselect;
    ready |-> chip_select_low_active && !chip_select_high_active &&
      upper_byte_lane_n && lower_byte_lane_n && writeStrobeN && outEnableN;
  endproperty
  a_deselect: assert property (p_deselect) else $error("not deselected while idle");

  property p_spacing;
    $fell(chip_select_low_active) |-> $past(sinceSel) >= TMR_W'(RC_CYC);
  endproperty
  a_spacing: assert property (p_spacing) else $error("accesses closer than cycle time");

  property p_err_write;
    (rspValid && opWrite) |-> !rspErr;
  endproperty
  a_err_write: assert property (p_err_write) else $error("error flag on a write");

endmodule

// [dv/sram_dev_model.sv]
// behavioural model of the asynchronous 256k x 16 sram with corrected-error flag
// assumes the host's registered pins; while the host drives data its value is the wire
module sram_dev_model #(
  parameter bit SLOW_GRADE = 1'b0
) (
  // address and controls from the host
  input  wire sram_ctrl_pkg::sram_addr_t sramAddr,
  input  wire logic                      chip_select_low_active,
  input  wire logic                      chip_select_high_active,
  input  wire logic                      upper_byte_lane_n,
  input  wire logic                      lower_byte_lane_n,
  input  wire logic                      writeStrobeN,
  input  wire logic                      outEnableN,
  // host data drive
  input  wire sram_ctrl_pkg::sram_data_t dataOut,
  input  wire logic                      dataOe,
  // address whose reads report a corrected bit
  input  wire sram_ctrl_pkg::sram_addr_t flagAddr,
  // wire levels seen by the host, and the violation count read by the bench
  output      sram_ctrl_pkg::sram_data_t dataIn,
  output      logic                      errIn,
  output      logic [7:0]                violations
);
  timeunit 1ns;
  timeprecision 1ns;
  import sram_ctrl_pkg::*;

  // ==========================================================
  // timing, worst case of each grade
  localparam realtime T_ACC  = SLOW_GRADE ? 55.0 : 45.0;
  localparam realtime T_OHA  = 10.0;
  localparam realtime T_AW   = SLOW_GRADE ? 45.0 : 35.0;
  localparam realtime T_BW   = SLOW_GRADE ? 45.0 : 35.0;
  localparam realtime T_PWE  = SLOW_GRADE ? 40.0 : 35.0;
  localparam realtime T_HZWE = SLOW_GRADE ? 20.0 : 18.0;
  localparam realtime T_SD   = 25.0;
  localparam realtime T_RC   = SLOW_GRADE ? 55.0 : 45.0;

  sram_data_t  mem [int];
  sram_data_t  rdWord = 16'h5a5a;
  sram_data_t  snapWord;
  sram_addr_t  snapAddr;
  sram_lanes_t snapLanes;
  logic        armed = 1'b0;
  logic        errDrv = 1'b0;
  logic [7:0]  viol = 8'h00;
  int          gen = 0;
  realtime     tAddr = 0.0;
  realtime     tLane = 0.0;
  realtime     tData = 0.0;
  realtime     tStrobe = 0.0;
  realtime     tSel = -1000.0;
  logic        selected;
  logic        reading;
  logic        wrActive;

  assign selected = !chip_select_low_active && chip_select_high_active &&
                    !(upper_byte_lane_n && lower_byte_lane_n);
  assign reading  = selected && writeStrobeN && !outEnableN;
  assign wrActive = selected && !writeStrobeN;
  assign dataIn   = dataOe ? dataOut : rdWord;
  assign errIn    = errDrv;
  assign violations = viol;

  // unwritten words read as an address-derived pattern
  function automatic sram_data_t lookup(input sram_addr_t a);
    return mem.exists(int'(a)) ? mem[int'(a)] : ~a[15:0];
  endfunction

  // ==========================================================
  // read side: old word briefly, then junk, then the new word
  always @(sramAddr, reading, upper_byte_lane_n, lower_byte_lane_n) begin
    gen = gen + 1;
    fork
      automatic int g = gen;
      begin
        #(T_OHA);
        if (g == gen) begin
          rdWord = ~rdWord;
          errDrv = ~errDrv;
        end
        #(T_ACC - T_OHA);
        if (g == gen) begin
          rdWord[7:0]  = (reading && !lower_byte_lane_n) ? lookup(sramAddr) & 16'h00ff
                                                         : ~rdWord[7:0];
          rdWord[15:8] = (reading && !upper_byte_lane_n) ? lookup(sramAddr) >> 8
                                                         : ~rdWord[15:8];
          errDrv = reading ? (sramAddr == flagAddr) : ~errDrv;
        end
      end
    join_none
  end

  // ==========================================================
  // write side: stamps for the host's timing duties
  always @(sramAddr) begin
    if (wrActive === 1'b1) viol = viol + 8'h01;
    tAddr = $realtime;
  end
  always @(negedge lower_byte_lane_n, negedge upper_byte_lane_n) tLane = $realtime;
  always @(dataOut, dataOe) tData = $realtime;
  always @(negedge writeStrobeN) tStrobe = $realtime;
  always @(negedge chip_select_low_active) begin
    if ($realtime - tSel < T_RC) viol = viol + 8'h01;
    tSel = $realtime;
  end

  // snapshot while the write overlap lasts, so a same-step release cannot race
  always @* begin
    if (wrActive === 1'b1) begin
      snapWord  = dataIn;
      snapAddr  = sramAddr;
      snapLanes = {!upper_byte_lane_n, !lower_byte_lane_n};
      armed     = 1'b1;
    end
  end

  always @(negedge wrActive) begin
    if (armed) begin
      if ($realtime - tAddr < T_AW) viol = viol + 8'h01;
      if ($realtime - tLane < T_BW) viol = viol + 8'h01;
      if ($realtime - tData < T_SD || dataOe !== 1'b1) viol = viol + 8'h01;
      if ($realtime - tStrobe < T_PWE) viol = viol + 8'h01;
      if (!outEnableN && $realtime - tStrobe < T_SD + T_HZWE) viol = viol + 8'h01;
      mem[int'(snapAddr)] = lookup(snapAddr);
      if (snapLanes[0]) mem[int'(snapAddr)][7:0] = snapWord[7:0];
      if (snapLanes[1]) mem[int'(snapAddr)][15:8] = snapWord[15:8];
      armed = 1'b0;
    end
  end
endmodule

// [dv/tb_sram_ctrl.sv]
// self-checking bench for the sram host controller against the device model
// assumes the default timer width and the fast grade on both sides
module tb_sram_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import sram_ctrl_pkg::*;

  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        req = 1'b0;
  logic        reqWrite = 1'b0;
  sram_addr_t  reqAddr = 18'h00000;
  sram_data_t  reqData = 16'h0000;
  sram_lanes_t reqLanes = 2'b00;
  sram_addr_t  flagAddr = 18'h3fff0;
  logic        ready, rspValid, rspErr, csLow, csHigh, upperN, lowerN;
  logic        writeStrobeN, outEnableN, dataOe, errIn;
  sram_data_t  rspData, dataOut, dataIn;
  sram_addr_t  sramAddr;
  logic [7:0]  devViolations;
  int          mismatches = 0;
  int          cmpCount = 0;
  int          cycles = 0;

  sram_ctrl #(.SLOW_GRADE(1'b0), .TMR_W(8)) DUT (
    .clk(clk), .sys_rst(sysRst), .req(req), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqLanes(reqLanes), .ready(ready), .rspValid(rspValid),
    .rspData(rspData), .rspErr(rspErr), .sramAddr(sramAddr),
    .chip_select_low_active(csLow), .chip_select_high_active(csHigh),
    .upper_byte_lane_n(upperN), .lower_byte_lane_n(lowerN),
    .writeStrobeN(writeStrobeN), .outEnableN(outEnableN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .errIn(errIn));

  sram_dev_model #(.SLOW_GRADE(1'b0)) device (
    .sramAddr(sramAddr), .chip_select_low_active(csLow), .chip_select_high_active(csHigh),
    .upper_byte_lane_n(upperN), .lower_byte_lane_n(lowerN), .writeStrobeN(writeStrobeN),
    .outEnableN(outEnableN), .dataOut(dataOut), .dataOe(dataOe), .flagAddr(flagAddr),
    .dataIn(dataIn), .errIn(errIn), .violations(devViolations));

  always #50 clk = ~clk;

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // entered at a falling edge with ready high; leaves at the falling edge ready returns
  task automatic access(input logic wr, input sram_addr_t a, input sram_data_t d,
                        input sram_lanes_t ln, output sram_data_t q, output logic e);
    int n;
    req = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    reqLanes = ln;
    @(negedge clk);
    req = 1'b0;
    check(outEnableN, wr);
    check(dataOe, wr);
    n = 1;
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(n, 4);
    q = rspData;
    e = rspErr;
    @(negedge clk);
    check(ready, 1'b1);
  endtask

  task automatic wrWord(input sram_addr_t a, input sram_data_t d, input sram_lanes_t ln);
    sram_data_t q;
    logic e;
    access(1'b1, a, d, ln, q, e);
    check(e, 1'b0);
  endtask

  task automatic rdCheck(input sram_addr_t a, input sram_lanes_t ln, input sram_data_t exp,
                         input logic expErr);
    sram_data_t q;
    logic e;
    access(1'b0, a, 16'h0000, ln, q, e);
    check(q, exp);
    check(e, expErr);
  endtask

  // ==========================================================
  // scenarios
  task automatic testIdlePins();
    check({ready, rspValid, writeStrobeN, outEnableN, dataOe}, 5'b10110);
    check({csLow, csHigh, upperN, lowerN}, 4'b1011);
    check(rspData, 16'h0000);
  endtask

  task automatic testWordRoundTrip();
    wrWord(18'h3ffff, 16'ha5c3, 2'b11);
    wrWord(18'h00000, 16'h1234, 2'b11);
    rdCheck(18'h3ffff, 2'b11, 16'ha5c3, 1'b0);
    rdCheck(18'h00000, 2'b11, 16'h1234, 1'b0);
  endtask

  task automatic testByteLanes();
    wrWord(18'h00155, 16'h1111, 2'b11);
    wrWord(18'h00155, 16'hab22, 2'b10);
    wrWord(18'h00155, 16'h33cd, 2'b01);
    rdCheck(18'h00155, 2'b11, 16'habcd, 1'b0);
    rdCheck(18'h00155, 2'b01, 16'h00cd, 1'b0);
    rdCheck(18'h00155, 2'b10, 16'hab00, 1'b0);
  endtask

  task automatic testDeselectByLanes();
    wrWord(18'h00155, 16'hffff, 2'b00);
    rdCheck(18'h00155, 2'b00, 16'h0000, 1'b0);
    rdCheck(18'h00155, 2'b11, 16'habcd, 1'b0);
  endtask

  task automatic testCorrectedFlag();
    flagAddr = 18'h00155;
    rdCheck(18'h00155, 2'b11, 16'habcd, 1'b1);
    rdCheck(18'h3ffff, 2'b11, 16'ha5c3, 1'b0);
    wrWord(18'h00155, 16'habcd, 2'b11);
  endtask

  // request held high through busy: only one take per free slot
  task automatic testBackToBack();
    int pulses;
    pulses = 0;
    req = 1'b1;
    reqWrite = 1'b1;
    reqAddr = 18'h002a0;
    reqData = 16'h0f0f;
    reqLanes = 2'b11;
    repeat (12) begin
      @(negedge clk);
      if (rspValid === 1'b1) pulses++;
    end
    req = 1'b0;
    check(pulses, 2);
    for (int i = 0; i < 10 && ready !== 1'b1; i++) @(negedge clk);
    rdCheck(18'h002a0, 2'b11, 16'h0f0f, 1'b0);
  endtask

  // ==========================================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    sysRst = 1'b0;
    @(negedge clk);
    testIdlePins();
    testWordRoundTrip();
    testByteLanes();
    testDeselectByLanes();
    testCorrectedFlag();
    testBackToBack();
    check(devViolations, 8'h00);
    conclude();
  end
endmodule
